//--- rtl/svwr_pkg.sv
// Shared constants and carrier types for the supply supervisor and watchdog block.
package svwr_pkg;
  // ==========================================================
  // Clock and timing.
  localparam int unsigned CLK_KHZ = 200000; // System clock in kHz (5 ns period).
  localparam int unsigned HOLD_MS = 250; // Reset hold after supply good or watchdog bite.
  localparam int unsigned WR_MS = 5; // Internally timed memory write cycle.
  localparam int unsigned WD0_MS = 200; // Watchdog preset 0.
  localparam int unsigned WD1_MS = 600; // Watchdog preset 1.
  localparam int unsigned WD2_MS = 1400; // Watchdog preset 2.
  localparam int unsigned HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam int unsigned WR_CYC = WR_MS * CLK_KHZ;
  localparam int unsigned WD0_CYC = WD0_MS * CLK_KHZ;
  localparam int unsigned WD1_CYC = WD1_MS * CLK_KHZ;
  localparam int unsigned WD2_CYC = WD2_MS * CLK_KHZ;
  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_CMIT = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  localparam logic [7:0] OFS_TRIP = 8'h18;
  // ==========================================================
  // Field layout and reset values.
  localparam int unsigned CTRL_W = 6; // [1:0] wd select, [2] protect_enable_bit, [5:3] block lock.
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [1:0] WD_OFF = 2'h3; // Select code that disables the watchdog.
  localparam logic [7:0] TRIP_KEY = 8'h5a; // Key that must directly precede a trip write.
  localparam logic [3:0] TRIP_RST = 4'h0;
  localparam int unsigned MEM_BYTES = 4096; // 32 kbit array.
  localparam int unsigned PAGE_BYTES = 64;
  localparam bit RST_ACT_HIGH = 1'b0; // Variant: 0 for active-low reset, 1 for active-high.
  // ==========================================================
  // Carrier types.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } svwr_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } svwr_wb_rsp_t;
  typedef enum logic [2:0] {
    RS_HOLD = 3'b001,
    RS_RUN = 3'b010,
    RS_LOW = 3'b100
  } svwr_rst_st_t;
  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_WRITE = 2'b10
  } svwr_mem_st_t;
endpackage

//--- rtl/svwr_top.sv
// Supply supervisor with watchdog, reset generator and page-written memory.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Reset held until supply good for 250ms.
// - Power-up reset lasts 250ms after stable supply.
// - Data falling with clock high restarts watchdog.
// - Missed watchdog restart asserts reset.
// - Three preset watchdog intervals selectable.
// - Selected interval kept in non-volatile storage; the code keeps it over supply loss but clears it on rst_b.
// - Control writes blocked when protect pin and bit.
// - Page writes up to 64 bytes.
// - Memory write self-timed, about 5ms.
// - Block lock: 1,2,4,8 pages, all, none.
// - Serial interface runs up to 400kHz.
// - Reset output open drain, either polarity.
// - Data line watched always, never gated.
// - Trip threshold adjustable by special sequence.
module svwr_top import svwr_pkg::*; #(
  parameter int unsigned P_HOLD_CYC = HOLD_CYC,
  parameter int unsigned P_WR_CYC = WR_CYC,
  parameter int unsigned P_WD0_CYC = WD0_CYC,
  parameter int unsigned P_WD1_CYC = WD1_CYC,
  parameter int unsigned P_WD2_CYC = WD2_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register bus.
  input svwr_wb_req_t wb_req,
  output svwr_wb_rsp_t wb_rsp,
  // Supply comparator and pins.
  input wire logic supply_ok,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic wp_pin,
  // Open-drain reset pin and trip trim.
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic [3:0] vtrip_code
);
  // ==========================================================
  // Helpers.
  // Maps a watchdog select code to its interval in cycles.
  function automatic logic [31:0] wd_limit(input logic [1:0] s);
    unique case (s)
      2'h0: wd_limit = P_WD0_CYC;
      2'h1: wd_limit = P_WD1_CYC;
      default: wd_limit = P_WD2_CYC;
    endcase
  endfunction
  // True when a page index falls in the locked top region.
  function automatic logic page_locked(input logic [2:0] code, input logic [5:0] pg);
    unique case (code)
      3'h0: page_locked = 1'b0;
      3'h1: page_locked = pg >= 6'd63;
      3'h2: page_locked = pg >= 6'd62;
      3'h3: page_locked = pg >= 6'd60;
      3'h4: page_locked = pg >= 6'd56;
      default: page_locked = 1'b1;
    endcase
  endfunction
  // ==========================================================
  // Bus slave.
  logic ack_ff, nxt_ack; // One-cycle ack, dropped the cycle after.
  logic [31:0] rdat_ff, nxt_rdat; // Read data registered with the ack.
  logic [31:0] rd_mux; // Read value of the addressed register.
  logic [31:0] wmask; // Write data masked by byte selects.
  logic wr_go, rd_go; // Access takes effect at the ack edge.
  assign wr_go = wb_req.cyc & wb_req.stb & wb_req.we & ack_ff;
  assign rd_go = wb_req.cyc & wb_req.stb & ~wb_req.we & ack_ff;
  assign wmask = wb_req.dat & {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
  assign wb_rsp.ack = ack_ff;
  assign wb_rsp.dat = rdat_ff;
  // ==========================================================
  // State.
  svwr_rst_st_t rst_st_ff, nxt_rst_st; // Reset generator state.
  logic [31:0] hold_cnt_ff, nxt_hold_cnt; // Reset hold timer.
  logic [31:0] wd_cnt_ff, nxt_wd_cnt; // Watchdog timer.
  logic wd_bite_ff, nxt_wd_bite; // Last reset came from the watchdog.
  logic sda_q_ff; // Previous data line sample.
  logic sda_fall; // Qualified restart event.
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl; // Control image; kept over supply loss, cleared by rst_b.
  logic key_ok_ff, nxt_key_ok; // Last write was the trip key.
  logic [3:0] trip_ff, nxt_trip; // Trip trim code.
  svwr_mem_st_t mem_st_ff, nxt_mem_st; // Memory write state.
  logic [31:0] wr_cnt_ff, nxt_wr_cnt; // Write cycle timer.
  logic [11:0] addr_ff, nxt_addr; // Memory pointer.
  logic [5:0] pg_ff, nxt_pg; // Page latched at the last data write.
  logic [63:0] pvld_ff, nxt_pvld; // Page buffer bytes pending.
  logic lock_err_ff, nxt_lock_err; // Last commit hit a locked page.
  logic [7:0] pbuf [PAGE_BYTES]; // Page buffer.
  logic [7:0] mem [MEM_BYTES]; // Memory array; survives supply loss.
  logic rst_act; // Reset asserted.
  logic data_wr, cmit_wr; // Accepted memory accesses.
  assign rst_act = rst_st_ff != RS_RUN;
  // The data line is sampled every cycle in every state; 200 MHz oversamples a 400 kHz bus widely.
  assign sda_fall = sda_q_ff & ~sda_in & scl_in;
  // Open drain: the pin is only ever pulled low; the active-high variant releases it to assert.
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = RST_ACT_HIGH ? ~rst_act : rst_act;
  assign vtrip_code = trip_ff;
  assign data_wr = wr_go & (wb_req.adr == OFS_DATA) & (mem_st_ff == MS_IDLE);
  assign cmit_wr = wr_go & (wb_req.adr == OFS_CMIT) & (mem_st_ff == MS_IDLE) & (|pvld_ff);
  // ==========================================================
  // Bus next state and read mux.
  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_req.adr)
      OFS_CTRL: rd_mux = {26'h0, ctrl_ff};
      OFS_STAT: rd_mux = {27'h0, lock_err_ff, wd_bite_ff, mem_st_ff == MS_WRITE, rst_act, supply_ok};
      OFS_ADDR: rd_mux = {20'h0, addr_ff};
      OFS_DATA: rd_mux = {24'h0, mem[addr_ff]};
      OFS_TRIP: rd_mux = {28'h0, trip_ff};
      default: rd_mux = 32'h0; // Unmapped and write-only offsets read as zero.
    endcase
    nxt_ack = wb_req.cyc & wb_req.stb & ~ack_ff;
    nxt_rdat = ack_ff ? rdat_ff : rd_mux;
  end
  // ==========================================================
  // Reset generator and watchdog next state.
  always_comb begin
    nxt_rst_st = rst_st_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_wd_cnt = wd_cnt_ff;
    nxt_wd_bite = wd_bite_ff;
    unique case (rst_st_ff)
      RS_LOW: begin
        nxt_hold_cnt = 32'h0;
        if (supply_ok) begin
          nxt_rst_st = RS_HOLD;
        end
      end
      RS_HOLD: begin
        // The hold time restarts whenever the supply dips again.
        if (!supply_ok) begin
          nxt_rst_st = RS_LOW;
        end else if (hold_cnt_ff == P_HOLD_CYC - 1) begin
          nxt_rst_st = RS_RUN;
          nxt_hold_cnt = 32'h0;
        end else begin
          nxt_hold_cnt = hold_cnt_ff + 32'h1;
        end
      end
      RS_RUN: begin
        if (!supply_ok) begin
          nxt_rst_st = RS_LOW;
          nxt_wd_bite = 1'b0;
        end else if (ctrl_ff[1:0] != WD_OFF && !sda_fall && wd_cnt_ff == wd_limit(ctrl_ff[1:0]) - 1) begin
          nxt_rst_st = RS_HOLD;
          nxt_wd_bite = 1'b1;
        end
      end
      default: nxt_rst_st = RS_LOW;
    endcase
    // The timer only runs out of reset, and any restart edge clears it.
    if (sda_fall || rst_st_ff != RS_RUN || ctrl_ff[1:0] == WD_OFF) begin
      nxt_wd_cnt = 32'h0;
    end else begin
      nxt_wd_cnt = wd_cnt_ff + 32'h1;
    end
  end
  // ==========================================================
  // Control, trim and memory next state.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_key_ok = key_ok_ff;
    nxt_trip = trip_ff;
    nxt_mem_st = mem_st_ff;
    nxt_wr_cnt = wr_cnt_ff;
    nxt_addr = addr_ff;
    nxt_pg = pg_ff;
    nxt_pvld = pvld_ff;
    nxt_lock_err = lock_err_ff;
    if (wr_go) begin
      nxt_key_ok = (wb_req.adr == OFS_KEY) && (wmask[7:0] == TRIP_KEY);
      if (wb_req.adr == OFS_CTRL && !(wp_pin && ctrl_ff[2])) begin
        nxt_ctrl = wmask[CTRL_W-1:0];
      end
      if (wb_req.adr == OFS_TRIP && key_ok_ff) begin
        nxt_trip = wmask[3:0];
      end
      if (wb_req.adr == OFS_ADDR && mem_st_ff == MS_IDLE) begin
        nxt_addr = wmask[11:0];
      end
    end
    if (data_wr) begin
      // The pointer wraps inside the page, so a long burst overwrites the page start.
      nxt_addr = {addr_ff[11:6], addr_ff[5:0] + 6'h1};
      nxt_pg = addr_ff[11:6];
      nxt_pvld = (addr_ff[11:6] == pg_ff ? pvld_ff : 64'h0) | (64'h1 << addr_ff[5:0]);
    end
    if (rd_go && wb_req.adr == OFS_DATA) begin
      nxt_addr = addr_ff + 12'h1;
    end
    unique case (mem_st_ff)
      MS_IDLE: begin
        if (cmit_wr) begin
          nxt_lock_err = page_locked(ctrl_ff[5:3], pg_ff);
          if (page_locked(ctrl_ff[5:3], pg_ff)) begin
            nxt_pvld = 64'h0;
          end else begin
            nxt_mem_st = MS_WRITE;
            nxt_wr_cnt = 32'h0;
          end
        end
      end
      MS_WRITE: begin
        if (wr_cnt_ff == P_WR_CYC - 1) begin
          nxt_mem_st = MS_IDLE;
          nxt_pvld = 64'h0;
        end else begin
          nxt_wr_cnt = wr_cnt_ff + 32'h1;
        end
      end
      default: nxt_mem_st = MS_IDLE;
    endcase
  end
  // ==========================================================
  // Registers.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
      rst_st_ff <= RS_HOLD;
      hold_cnt_ff <= 32'h0;
      wd_cnt_ff <= 32'h0;
      wd_bite_ff <= 1'b0;
      sda_q_ff <= 1'b1;
      ctrl_ff <= CTRL_RST;
      key_ok_ff <= 1'b0;
      trip_ff <= TRIP_RST;
      mem_st_ff <= MS_IDLE;
      wr_cnt_ff <= 32'h0;
      addr_ff <= 12'h0;
      pg_ff <= 6'h0;
      pvld_ff <= 64'h0;
      lock_err_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      rst_st_ff <= nxt_rst_st;
      hold_cnt_ff <= nxt_hold_cnt;
      wd_cnt_ff <= nxt_wd_cnt;
      wd_bite_ff <= nxt_wd_bite;
      sda_q_ff <= sda_in;
      ctrl_ff <= nxt_ctrl;
      key_ok_ff <= nxt_key_ok;
      trip_ff <= nxt_trip;
      mem_st_ff <= nxt_mem_st;
      wr_cnt_ff <= nxt_wr_cnt;
      addr_ff <= nxt_addr;
      pg_ff <= nxt_pg;
      pvld_ff <= nxt_pvld;
      lock_err_ff <= nxt_lock_err;
    end
  end
  // ==========================================================
  // Storage arrays; no reset: the array models non-volatile cells, and buffer bytes count only when pvld_ff marks them.
  // Bytes are buffered on data writes and moved into the array at the end of the cycle.
  always_ff @(posedge clk_sys) begin
    if (data_wr) begin
      pbuf[addr_ff[5:0]] <= wmask[7:0];
    end
  end
  // One process owns the whole array, so the array never has several drivers.
  always_ff @(posedge clk_sys) begin
    if (mem_st_ff == MS_WRITE && wr_cnt_ff == P_WR_CYC - 1) begin
      for (int g = 0; g < PAGE_BYTES; g++) begin
        if (pvld_ff[g]) begin
          mem[{pg_ff, 6'(g)}] <= pbuf[g];
        end
      end
    end
  end
  // ==========================================================
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  hold_len_a: assert property ($fell(rst_act) |-> $past(hold_cnt_ff) == P_HOLD_CYC - 1)
    else $error("Reset released before the hold time ran out.");
  low_supply_a: assert property (!supply_ok |=> rst_act [*2])
    else $error("Reset not held while supply is low.");
  por_start_a: assert property ($rose(rst_b) |-> rst_act)
    else $error("Reset not asserted after power-up.");
  wd_restart_a: assert property (sda_fall |=> wd_cnt_ff == 32'h0)
    else $error("Watchdog not restarted by the data edge.");
  wd_bite_a: assert property (rst_st_ff == RS_RUN && supply_ok && !sda_fall && ctrl_ff[1:0] != WD_OFF
    && wd_cnt_ff == wd_limit(ctrl_ff[1:0]) - 1 |=> rst_st_ff == RS_HOLD && wd_bite_ff)
    else $error("Watchdog timeout did not assert reset.");
  wd_off_a: assert property (rst_st_ff == RS_RUN && supply_ok && ctrl_ff[1:0] == WD_OFF |=> !rst_act)
    else $error("Disabled watchdog asserted reset.");
  ctrl_lock_a: assert property (wr_go && wb_req.adr == OFS_CTRL && wp_pin && ctrl_ff[2] |=> $stable(ctrl_ff))
    else $error("Protected control register changed.");
  page_wrap_a: assert property (data_wr |=> addr_ff[5:0] == $past(addr_ff[5:0]) + 6'h1
    && addr_ff[11:6] == $past(addr_ff[11:6]))
    else $error("Page pointer left its page.");
  wr_len_a: assert property ($fell(mem_st_ff == MS_WRITE) |-> $past(wr_cnt_ff) == P_WR_CYC - 1)
    else $error("Write cycle ended early.");
  lock_a: assert property (cmit_wr && page_locked(ctrl_ff[5:3], pg_ff) |=> mem_st_ff == MS_IDLE && lock_err_ff)
    else $error("Locked page was written.");
  od_pin_a: assert property (!rst_pin_o && rst_pin_oe == (rst_act ^ RST_ACT_HIGH))
    else $error("Reset pin not open drain with the right polarity.");
  trip_key_a: assert property (wr_go && wb_req.adr == OFS_TRIP && !key_ok_ff |=> $stable(trip_ff))
    else $error("Trip code changed without the key.");
endmodule

//--- bench/svwr_host.sv
// Host model that services the watchdog over the two-wire bus lines.
`timescale 1ns/1ps
module svwr_host #(
  parameter int unsigned P_PERIOD = 10
) (
  // Clock.
  input wire logic clk_sys,
  // Service enable from the bench.
  input wire logic auto_kick,
  // Bus lines, pulled up whenever released.
  output logic scl,
  output logic sda
);
  // ==========================================================
  // Idle bus: both lines rest at the pull-up level.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Data falls while the clock stays high, then rises again as a stop.
  task automatic kick();
    @(posedge clk_sys);
    sda <= 1'b0;
    repeat (2) @(posedge clk_sys);
    sda <= 1'b1;
  endtask
  // Data moves only while the clock is low, so no restart may be seen.
  task automatic wiggle();
    @(posedge clk_sys);
    scl <= 1'b0;
    @(posedge clk_sys);
    sda <= 1'b0;
    @(posedge clk_sys);
    scl <= 1'b1;
    @(posedge clk_sys);
    scl <= 1'b0;
    @(posedge clk_sys);
    sda <= 1'b1;
    @(posedge clk_sys);
    scl <= 1'b1;
  endtask
  // Periodic service, well inside the shortest timeout.
  always begin
    repeat (P_PERIOD) @(posedge clk_sys);
    if (auto_kick) begin
      kick();
    end
  end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the supervisor, watchdog and memory block.
`timescale 1ns/1ps
module testbench;
  import svwr_pkg::*;
  // ==========================================================
  // Shortened counts; the hold and watchdog timing checks derive from these.
  localparam int unsigned HOLD = 20;
  localparam int unsigned WRC = 10;
  localparam int unsigned WD0 = 30;
  localparam int unsigned WD1 = 50;
  localparam int unsigned WD2 = 70;
  logic clk_sys, rst_b, supply_ok, wp_pin, auto_kick, scl, sda;
  logic rst_pin_o, rst_pin_oe;
  logic [3:0] vtrip_code;
  svwr_wb_req_t wb_req;
  svwr_wb_rsp_t wb_rsp;
  logic [31:0] q; // Data of the last bus read.
  int errors, n_tests, cyc_n, t0, n, lim;
  svwr_top #(.P_HOLD_CYC(HOLD), .P_WR_CYC(WRC), .P_WD0_CYC(WD0), .P_WD1_CYC(WD1), .P_WD2_CYC(WD2)) svwr_top_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp), .supply_ok(supply_ok),
    .scl_in(scl), .sda_in(sda), .wp_pin(wp_pin), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .vtrip_code(vtrip_code));
  svwr_host svwr_host_i (.clk_sys(clk_sys), .auto_kick(auto_kick), .scl(scl), .sda(sda));
  // ==========================================================
  // Clock, cycle count and watchdog on the run itself.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc_n <= cyc_n + 1;
  initial begin
    #50000;
    errors++;
    wrap_up();
  end
  // ==========================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic near(input int e, input int l);
    return (e >= l - 4) && (e <= l + 4); // Tolerates the register stages on either end.
  endfunction
  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    wb_req <= {1'b1, 1'b1, we, 4'hf, a, d}; // Fields in order: cyc, stb, we, sel, adr, dat.
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
    end
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask
  // Waits on falling edges, where the pin decode has settled.
  task automatic wait_oe(input logic lvl);
    n = 0;
    while (rst_pin_oe !== lvl && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 5000) begin
      errors++;
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    errors = 0;
    n_tests = 0;
    cyc_n = 0;
    rst_b = 1'b0;
    supply_ok = 1'b1;
    wp_pin = 1'b0;
    auto_kick = 1'b1;
    wb_req = '0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(rst_pin_oe, 1'b1);
    check(rst_pin_o, 1'b0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    t0 = cyc_n;
    wait_oe(1'b0);
    check(near(cyc_n - t0, HOLD), 1'b1);
    // Reset values, an unmapped place, and the supply flag.
    wb(1'b0, OFS_CTRL, '0);
    check(q, 32'h0);
    wb(1'b0, 8'h1c, '0);
    check(q, 32'h0);
    wb(1'b0, OFS_STAT, '0);
    check(q[1:0], 2'b01);
    // Trim changes only right after the key.
    wb(1'b1, OFS_TRIP, 32'h9);
    @(negedge clk_sys);
    check(vtrip_code, TRIP_RST);
    wb(1'b1, OFS_KEY, {24'h0, TRIP_KEY});
    wb(1'b1, OFS_TRIP, 32'h9);
    wb(1'b0, OFS_TRIP, '0);
    check(q, 32'h9);
    check(vtrip_code, 4'h9);
    // A full page, committed and timed, then read back.
    wb(1'b1, OFS_ADDR, 32'h40);
    for (int i = 0; i < PAGE_BYTES; i++) wb(1'b1, OFS_DATA, 32'(i ^ 8'h5c));
    wb(1'b1, OFS_CMIT, '0);
    wb(1'b0, OFS_STAT, '0);
    check(q[2], 1'b1);
    n = 0;
    while (q[2] !== 1'b0 && n < 20) begin
      wb(1'b0, OFS_STAT, '0);
      n++;
    end
    check(n >= 2 && n <= 5, 1'b1);
    wb(1'b1, OFS_ADDR, 32'h40);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      wb(1'b0, OFS_DATA, '0);
      check(q[7:0], 8'(i ^ 8'h5c));
    end
    // One locked top page refuses the commit without going busy.
    wb(1'b1, OFS_CTRL, 32'h08);
    wb(1'b1, OFS_ADDR, 32'hfc0);
    wb(1'b1, OFS_DATA, 32'haa);
    wb(1'b1, OFS_CMIT, '0);
    wb(1'b0, OFS_STAT, '0);
    check(q[4:2], 3'b100);
    // Eight locked pages refuse page 56 and take page 55; a full lock refuses page 0.
    for (int c = 0; c < 3; c++) begin
      wb(1'b1, OFS_CTRL, (c == 2) ? 32'h28 : 32'h20);
      wb(1'b1, OFS_ADDR, (c == 1) ? 32'hdc0 : (c == 0) ? 32'he00 : 32'h000);
      wb(1'b1, OFS_DATA, 32'h11);
      wb(1'b1, OFS_CMIT, '0);
      wb(1'b0, OFS_STAT, '0);
      check(q[4:2], (c == 1) ? 3'b001 : 3'b100);
      repeat (WRC) @(posedge clk_sys);
    end
    // Protect pin together with the enable bit blocks control writes.
    wb(1'b1, OFS_CTRL, 32'h04);
    @(posedge clk_sys);
    wp_pin <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'h01);
    wb(1'b0, OFS_CTRL, '0);
    check(q, 32'h04);
    @(posedge clk_sys);
    wp_pin <= 1'b0;
    wb(1'b1, OFS_CTRL, 32'h00);
    wb(1'b0, OFS_CTRL, '0);
    check(q, 32'h00);
    // Each preset bites when service stops; clock-low data moves do not restart preset 0.
    for (int s = 0; s < 3; s++) begin
      lim = (s == 0) ? WD0 : (s == 1) ? WD1 : WD2;
      wb(1'b1, OFS_CTRL, 32'(s));
      auto_kick <= 1'b0;
      repeat (12) @(posedge clk_sys);
      svwr_host_i.kick();
      t0 = cyc_n - 2;
      if (s == 0) begin
        repeat (8) @(posedge clk_sys);
        svwr_host_i.wiggle();
      end
      wait_oe(1'b1);
      check(near(cyc_n - t0, lim), 1'b1);
      wb(1'b0, OFS_STAT, '0);
      check(q[3], 1'b1);
      wait_oe(1'b0);
      @(posedge clk_sys);
      auto_kick <= 1'b1;
    end
    // The off code keeps reset away with no service at all.
    wb(1'b1, OFS_CTRL, {30'h0, WD_OFF});
    auto_kick <= 1'b0;
    repeat (3 * WD2) @(negedge clk_sys);
    check(rst_pin_oe, 1'b0);
    @(posedge clk_sys);
    auto_kick <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'h02);
    // Supply loss holds reset, release follows the hold time, selection survives.
    @(posedge clk_sys);
    supply_ok <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check(rst_pin_oe, 1'b1);
    repeat (40) @(posedge clk_sys);
    wb(1'b0, OFS_STAT, '0);
    check(q[1:0], 2'b10);
    @(posedge clk_sys);
    supply_ok <= 1'b1;
    t0 = cyc_n;
    wait_oe(1'b0);
    check(near(cyc_n - t0, HOLD), 1'b1);
    wb(1'b0, OFS_CTRL, '0);
    check(q, 32'h02);
    wrap_up();
  end
endmodule
